// ===== design/actc_pkg.sv
package actc_pkg;

    // basic-clock divider select codes and their CPU-clock divisors
    localparam logic [1:0] BC_SEL_DIV4    = 2'h0;
    localparam logic [1:0] BC_SEL_DIV2    = 2'h1;
    localparam logic [1:0] BC_SEL_DIV16   = 2'h2;
    localparam logic [1:0] BC_SEL_DIV8    = 2'h3;
    localparam logic [4:0] BC_DIV_CODE_00 = 5'h04;
    localparam logic [4:0] BC_DIV_CODE_01 = 5'h02;
    localparam logic [4:0] BC_DIV_CODE_10 = 5'h10;
    localparam logic [4:0] BC_DIV_CODE_11 = 5'h08;
    localparam int         BC_CNT_W       = 5;

    // sample window length in basic-clock periods
    localparam logic [6:0] SMP_LEN_CODE_00 = 7'h08;
    localparam logic [6:0] SMP_LEN_CODE_01 = 7'h10;
    localparam logic [6:0] SMP_LEN_CODE_10 = 7'h20;
    localparam logic [6:0] SMP_LEN_CODE_11 = 7'h40;

    // conversion tail
    localparam logic [6:0] CONV_BC_PERIODS   = 7'h28;
    localparam logic [1:0] FINISH_CPU_CYCLES = 2'h2;

    // clock and widths
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         RESULT_W      = 10;
    localparam int         TIME_W        = 12;

    // reset values
    localparam logic [1:0] SEL_RST = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11,
        ST_FINISH  = 2'b10
    } actc_state_t;

    function automatic logic [4:0] bc_div(input logic [1:0] sel);
        unique case (sel)
            BC_SEL_DIV4:  bc_div = BC_DIV_CODE_00;
            BC_SEL_DIV2:  bc_div = BC_DIV_CODE_01;
            BC_SEL_DIV16: bc_div = BC_DIV_CODE_10;
            BC_SEL_DIV8:  bc_div = BC_DIV_CODE_11;
        endcase
    endfunction

    function automatic logic [6:0] smp_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: smp_len = SMP_LEN_CODE_00;
            2'h1: smp_len = SMP_LEN_CODE_01;
            2'h2: smp_len = SMP_LEN_CODE_10;
            2'h3: smp_len = SMP_LEN_CODE_11;
        endcase
    endfunction

endpackage

// ===== design/actc_bc_div.sv
`timescale 1ns/100ps
module actc_bc_div
    import actc_pkg::*;
#(
    parameter int CNT_W = BC_CNT_W
) (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    // control
    input  wire logic       i_restart,
    input  wire logic [1:0] i_div_sel,
    // basic-clock period tick
    output logic            o_tick
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } actc_div_reg_t;

    actc_div_reg_t    r_ff;
    actc_div_reg_t    nxt_r;
    logic [CNT_W-1:0] div_last;

    assign div_last = CNT_W'(bc_div(i_div_sel) - 5'h01);
    assign o_tick   = !i_restart && (r_ff.cnt == div_last);

    always_comb begin
        nxt_r = r_ff;
        if (i_restart || r_ff.cnt == div_last) begin
            nxt_r.cnt = '0;
        end else begin
            nxt_r.cnt = r_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // helper: cycles since the previous tick
    logic [CNT_W:0] gap_ff;
    logic           seen_ff;

    always_ff @(posedge i_mclk) begin
        if (i_reset || i_restart) begin
            gap_ff  <= '0;
            seen_ff <= 1'b0;
        end else if (o_tick) begin
            gap_ff  <= '0;
            seen_ff <= 1'b1;
        end else begin
            gap_ff  <= gap_ff + (CNT_W+1)'(1);
        end
    end

    chk_tick_period: assert property (@(posedge i_mclk) disable iff (i_reset)
        (o_tick && seen_ff) |-> (gap_ff == (CNT_W+1)'(bc_div(i_div_sel) - 5'h01)))
        else $error("basic clock period does not match divider select");

endmodule // actc_bc_div

// ===== design/actc_top.sv
// Behaviour
// - divider select 00/01/10/11 gives basic clock of CPU clock /4, /2, /16, /8
// - sample select 00/01/10/11 opens window of 8, 16, 32, 64 basic periods
// - conversion lasts sample window plus 40 basic periods plus 2 CPU clocks
// - input is taken only inside the window; later changes leave the result alone
`timescale 1ns/100ps
module actc_top
    import actc_pkg::*;
#(
    parameter int RES_W = RESULT_W
) (
    // clock and reset
    input  wire logic             I_MCLK,
    input  wire logic             I_RESET,
    // converter control word fields
    input  wire logic [1:0]       I_BASIC_CLOCK_DIVIDER_SELECT,
    input  wire logic [1:0]       I_SAMPLE_TIME_SELECT,
    input  wire logic             I_START,
    // quantised analog input from the pins
    input  wire logic [RES_W-1:0] I_ANALOG,
    // status and result
    output logic                  O_BUSY,
    output logic                  O_SAMPLING,
    output logic                  O_BC_TICK,
    output logic                  O_DONE,
    output logic [RES_W-1:0]      O_RESULT
);

    typedef struct packed {
        actc_state_t      state;
        logic [1:0]       div_sel;
        logic [1:0]       sts_sel;
        logic [6:0]       bc_cnt;
        logic [1:0]       fin_cnt;
        logic [RES_W-1:0] sync1;
        logic [RES_W-1:0] sync2;
        logic [RES_W-1:0] sync3;
        logic [RES_W-1:0] accepted;
        logic [RES_W-1:0] held;
        logic             busy;
        logic             sampling;
        logic             bc_tick;
        logic             done;
        logic [RES_W-1:0] result;
    } actc_reg_t;

    actc_reg_t  r_ff;
    actc_reg_t  nxt_r;
    logic       start_take;
    logic       tick;
    logic [1:0] div_use;

    assign start_take = I_START && (r_ff.state == ST_IDLE);
    // selects are frozen per conversion; a mid-conversion write waits for the next one
    assign div_use    = start_take ? I_BASIC_CLOCK_DIVIDER_SELECT : r_ff.div_sel;

    actc_bc_div #(
        .CNT_W (BC_CNT_W)
    ) actc_bc_div_inst (
        .i_mclk    (I_MCLK),
        .i_reset   (I_RESET),
        .i_restart (start_take),
        .i_div_sel (div_use),
        .o_tick    (tick)
    );

    always_comb begin
        nxt_r         = r_ff;
        nxt_r.done    = 1'b0;
        nxt_r.bc_tick = tick && (r_ff.state != ST_IDLE);
        // three-stage pin synchroniser, change taken once stages two and three agree
        nxt_r.sync1   = I_ANALOG;
        nxt_r.sync2   = r_ff.sync1;
        nxt_r.sync3   = r_ff.sync2;
        if (r_ff.sync2 == r_ff.sync3) begin
            nxt_r.accepted = r_ff.sync3;
        end
        unique case (r_ff.state)
            ST_IDLE: begin
                if (start_take) begin
                    nxt_r.state   = ST_SAMPLE;
                    nxt_r.div_sel = I_BASIC_CLOCK_DIVIDER_SELECT;
                    nxt_r.sts_sel = I_SAMPLE_TIME_SELECT;
                    nxt_r.bc_cnt  = '0;
                end
            end
            ST_SAMPLE: begin
                nxt_r.held = r_ff.accepted;
                if (tick) begin
                    if (r_ff.bc_cnt == smp_len(r_ff.sts_sel) - 7'h01) begin
                        nxt_r.state  = ST_CONVERT;
                        nxt_r.bc_cnt = '0;
                    end else begin
                        nxt_r.bc_cnt = r_ff.bc_cnt + 7'h01;
                    end
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (r_ff.bc_cnt == CONV_BC_PERIODS - 7'h01) begin
                        nxt_r.state   = ST_FINISH;
                        nxt_r.fin_cnt = '0;
                    end else begin
                        nxt_r.bc_cnt = r_ff.bc_cnt + 7'h01;
                    end
                end
            end
            ST_FINISH: begin
                if (r_ff.fin_cnt == FINISH_CPU_CYCLES - 2'h1) begin
                    nxt_r.state  = ST_IDLE;
                    nxt_r.done   = 1'b1;
                    nxt_r.result = r_ff.held;
                end else begin
                    nxt_r.fin_cnt = r_ff.fin_cnt + 2'h1;
                end
            end
        endcase
        nxt_r.busy     = (nxt_r.state != ST_IDLE);
        nxt_r.sampling = (nxt_r.state == ST_SAMPLE);
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            r_ff         <= '0;
            r_ff.state   <= ST_IDLE;
            r_ff.div_sel <= SEL_RST;
            r_ff.sts_sel <= SEL_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign O_BUSY     = r_ff.busy;
    assign O_SAMPLING = r_ff.sampling;
    assign O_BC_TICK  = r_ff.bc_tick;
    assign O_DONE     = r_ff.done;
    assign O_RESULT   = r_ff.result;

    // helper: elapsed CPU cycles of the running conversion and of its window
    logic [TIME_W-1:0] elapsed_ff;
    logic [TIME_W-1:0] win_ff;
    logic [TIME_W-1:0] exp_total;
    logic [TIME_W-1:0] exp_win;
    logic [RES_W-1:0]  win_end_val_ff;

    assign exp_win   = TIME_W'(smp_len(r_ff.sts_sel)) * TIME_W'(bc_div(r_ff.div_sel));
    assign exp_total = (TIME_W'(smp_len(r_ff.sts_sel)) + TIME_W'(CONV_BC_PERIODS))
                       * TIME_W'(bc_div(r_ff.div_sel)) + TIME_W'(FINISH_CPU_CYCLES);

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            elapsed_ff     <= '0;
            win_ff         <= '0;
            win_end_val_ff <= '0;
        end else if (start_take) begin
            elapsed_ff <= '0;
            win_ff     <= '0;
        end else begin
            if (r_ff.busy) begin
                elapsed_ff <= elapsed_ff + TIME_W'(1);
            end
            if (r_ff.sampling) begin
                win_ff         <= win_ff + TIME_W'(1);
                win_end_val_ff <= r_ff.accepted;
            end
        end
    end

    sequence seq_finish_tail;
        (r_ff.state == ST_FINISH) [*2] ##1 (O_DONE && !O_BUSY);
    endsequence

    sequence seq_window_close;
        O_SAMPLING ##1 !O_SAMPLING;
    endsequence

    chk_total_time: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        O_DONE |-> (elapsed_ff == exp_total))
        else $error("conversion time differs from window plus 40 basic plus 2 cpu");

    chk_finish_tail: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        ($rose(r_ff.state == ST_FINISH)) |-> seq_finish_tail)
        else $error("finish phase not two cpu cycles ending in done");

    chk_window_len: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        seq_window_close |-> (win_ff == exp_win))
        else $error("sample window length differs from selected count");

    chk_result_frozen: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        O_DONE |-> (O_RESULT == win_end_val_ff))
        else $error("result is not the value taken at window close");

    chk_hold_outside: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (r_ff.state == ST_CONVERT) |=> $stable(r_ff.held))
        else $error("held sample moved after window closed");

    chk_tick_rate: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        (O_BC_TICK && r_ff.div_sel == BC_SEL_DIV4 && r_ff.state == ST_CONVERT
         && $past(r_ff.state) == ST_CONVERT && r_ff.bc_cnt < 7'h26)
        |=> (!O_BC_TICK) [*3] ##1 O_BC_TICK)
        else $error("divide-by-four basic clock not every fourth cycle");

endmodule // actc_top

// ===== test/actc_top_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("FAIL %0t %s", $time, msg); \
        end \
    end

module actc_top_tb
    import actc_pkg::*;
;
    logic       mclk;
    logic       reset;
    logic [1:0] div_sel;
    logic [1:0] smp_sel;
    logic       start;
    logic [9:0] analog;
    logic       busy;
    logic       sampling;
    logic       bc_tick;
    logic       done;
    logic [9:0] result;
    int         err_count;
    int         check_count;
    logic [9:0] vals [4] = '{10'h3A5, 10'h05A, 10'h2C3, 10'h13C};

    actc_top actc_top_inst (
        .I_MCLK                       (mclk),
        .I_RESET                      (reset),
        .I_BASIC_CLOCK_DIVIDER_SELECT (div_sel),
        .I_SAMPLE_TIME_SELECT         (smp_sel),
        .I_START                      (start),
        .I_ANALOG                     (analog),
        .O_BUSY                       (busy),
        .O_SAMPLING                   (sampling),
        .O_BC_TICK                    (bc_tick),
        .O_DONE                       (done),
        .O_RESULT                     (result)
    );

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    task automatic end_sim;
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one conversion; a held start is taken again in the done cycle
    task automatic conv(input logic [1:0] div, input logic [1:0] smp,
                        input logic [9:0] vin, input logic [9:0] vout, input bit hold);
        int d;
        int t;
        int n;
        int t_got;
        int smp_cnt;
        int last_tick;
        bit was_high;
        bit fell;
        d = (div == 2'h0) ? 4 : (div == 2'h1) ? 2 : (div == 2'h2) ? 16 : 8;
        t = ((8 << smp) + 40) * d + 2;
        t_got = 0;
        smp_cnt = 0;
        last_tick = 0;
        fell = 0;
        @(posedge mclk);
        was_high = (start === 1'b1);
        // every divider is assumed legal for the 25 MHz bench clock
        div_sel <= div;
        smp_sel <= smp;
        analog  <= vin;
        if (!was_high) begin
            start <= 1'b1;
            @(posedge mclk);
        end
        start <= hold;
        // the first window cycle lies before the loop's first edge
        #1;
        if (sampling === 1'b1) smp_cnt++;
        for (n = 1; n <= 3000 && t_got == 0; n++) begin
            @(posedge mclk);
            // input swapped only once the window has closed
            if (fell) analog <= vout;
            #1;
            if (n == 1) `CHK({busy, sampling}, 2'h3, "busy or window not raised")
            if (sampling === 1'b1) smp_cnt++;
            if (sampling !== 1'b1 && smp_cnt > 0) fell = 1;
            if (bc_tick === 1'b1) begin
                if (last_tick > 0) `CHK(n - last_tick, d, "basic tick spacing")
                last_tick = n;
            end
            if (done === 1'b1) t_got = n;
        end
        if (t_got == 0) begin
            err_count++;
            $display("FAIL %0t no completion", $time);
            end_sim();
        end else begin
            `CHK(t_got, t, "conversion length")
            `CHK(smp_cnt, (8 << smp) * d, "window length")
            `CHK(result, vin, "result not window value")
            `CHK(busy, 1'b0, "busy at completion")
            `CHK(last_tick > 0, 1'b1, "no basic ticks")
        end
    endtask

    task automatic t_dividers;
        for (int i = 0; i < 4; i++) begin
            conv(2'(i), 2'h0, vals[i], ~vals[i], 1'b0);
        end
    endtask

    task automatic t_windows;
        for (int i = 0; i < 4; i++) begin
            conv(2'h1, 2'(i), vals[3 - i], ~vals[3 - i], 1'b0);
        end
    endtask

    // start held high through the run: ignored while busy, retaken in the done cycle;
    // the retaken run captures its selects before the call sets them, so both match
    task automatic t_chain;
        conv(2'h3, 2'h1, 10'h1E1, 10'h21E, 1'b1);
        conv(2'h3, 2'h1, 10'h0F0, 10'h30F, 1'b0);
    endtask

    task automatic t_mid_reset;
        @(posedge mclk);
        div_sel <= 2'h0;
        smp_sel <= 2'h0;
        start   <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (20) @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        reset <= 1'b0;
        #1;
        `CHK({busy, sampling, bc_tick, done, result}, 14'h0000, "after reset")
        conv(2'h2, 2'h0, 10'h155, 10'h2AA, 1'b0);
    endtask

    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        div_sel = 2'h0;
        smp_sel = 2'h0;
        start = 1'b0;
        analog = 10'h000;
        err_count = 0;
        check_count = 0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK({busy, sampling, bc_tick, done, result}, 14'h0000, "after power-up")
        t_dividers();
        t_windows();
        t_chain();
        t_mid_reset();
        end_sim();
    end
endmodule // actc_top_tb
